/* File: slpm_top.sv */
// Overview of operation
// [R01] With manual addressing on, every slave uses the station address software wrote for it.
// [R02] With manual addressing off, slave one uses the first address and the rest count upward.
// [R03] With user connect flags selected, only slaves whose link flag is set are polled.
// [R04] With user connect flags not selected, every addressed slave is polled.
// [R05] With simultaneous read-write on, each slave gets one combined read-write exchange.
// [R06] With simultaneous read-write off, each slave gets a separate read and then a write.
// [R07] In manual mode the number of finished passes is kept and compared with the target.
// [R08] A zero target is illegal and raises the zero count error flag.
// [R09] Software loads the target before setting manual mode and link enable.
// [R10] When the pass count reaches the target the link stops and clears link enable itself.
// [R11] Software sets manual mode and link enable again to repeat a manual run.
// [R12] In auto mode with link enable set the link polls without end until either bit clears.
// [R13] Software sets link enable only after all other settings are made.
// [R14] Auto and manual mode together raise the mode conflict error and clear link enable.
// [R15] Protocol select clear means standard framing and set means the extended framing.
// [R16] The timeout flag sets on an unanswered exchange and clears on one that completes.
// [R17] The pass count steps once per full pass and restarts from zero with each manual run; the code steps it only in manual mode.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
module slpm_top
  import slpm_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Avalon-MM register slave.
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output      logic [31:0] o_readdata,
  output      logic        o_waitrequest,
  // Serial transaction engine.
  output      logic        o_req_valid,
  input  wire logic        i_req_ready,
  output      slpm_req_t   o_req,
  input  wire slpm_rsp_t   i_rsp,
  // Status levels.
  output      logic        o_busy,
  output      logic        o_error
);

  typedef enum {
    SLPM_IDLE,
    SLPM_SCAN,
    SLPM_ISSUE,
    SLPM_WAIT,
    SLPM_PASS_END
  } slpm_state_t;

  slpm_state_t          state;
  slpm_state_t          next_state;
  logic [CTL_WIDTH-1:0] control;
  logic                 ctl_write;
  logic [7:0]           first_addr;
  logic [31:0]          link_flags;
  logic [15:0]          target;
  logic [15:0]          done_count;
  logic [7:0]           user_addr;
  logic [7:0]           station;
  logic [4:0]           index;
  logic                 write_phase;
  logic                 timeout_flag;
  logic                 conflict_error;
  logic                 clear_enable;
  slpm_req_t            next_req;
  logic                 next_write;

  // ==========================================================================
  // Control bits.
  // ==========================================================================
  wire logic link_enable = control[CTL_LINK_ENABLE];
  wire logic auto_run    = control[CTL_AUTO_RUN];
  wire logic manual_run  = control[CTL_MANUAL_RUN];
  wire logic user_flags  = control[CTL_USER_FLAGS];
  wire logic manual_addr = control[CTL_MANUAL_ADDR];
  wire logic simul_rw    = control[CTL_SIMUL_RW];
  wire logic protocol    = control[CTL_PROTOCOL_SEL];

  // Zero target is reported at all times, not only while running.
  wire logic zero_count  = (target == 16'h0000); // [R08]
  wire logic both_modes  = auto_run & manual_run;
  // A run needs exactly one mode and, for manual runs, a legal target.
  wire logic run_ok      = link_enable & ~both_modes & (auto_run | (manual_run & ~zero_count));

  // ==========================================================================
  // Register file and station address source.
  // ==========================================================================
  slpm_regs u_regs (
    .i_clock        (i_clock),
    .i_rst          (i_rst),
    .i_address      (i_address),
    .i_read         (i_read),
    .i_write        (i_write),
    .i_writedata    (i_writedata),
    .i_byteenable   (i_byteenable),
    .o_readdata     (o_readdata),
    .o_waitrequest  (o_waitrequest),
    .o_control      (control),
    .o_ctl_write    (ctl_write),
    .o_first_addr   (first_addr),
    .o_link_flags   (link_flags),
    .o_target       (target),
    .i_stn_index    (index),
    .o_stn_addr     (user_addr),
    .i_clear_enable (clear_enable),
    .i_status       ({o_busy, timeout_flag, conflict_error, zero_count}),
    .i_done_count   (done_count)
  );

  slpm_addr_gen u_addr (
    .i_manual_addr (manual_addr),
    .i_first_addr  (first_addr),
    .i_index       (index),
    .i_user_addr   (user_addr),
    .o_station     (station)
  );

  // ==========================================================================
  // Slave selection.
  // ==========================================================================
  // Every station slot counts as addressed, so without user flags all poll.
  wire logic slave_on  = user_flags ? link_flags[index] : 1'b1; // [R03] [R04]
  wire logic last_slot = (index == 5'(NUM_SLAVES - 1));
  // A pass with no selected slave still ends so that manual runs finish.
  wire logic pass_hit  = manual_run & ((done_count + 16'h0001) >= target);

  // Hardware clears link enable on conflict, on a zero manual target, or when the target is met.
  assign clear_enable = link_enable & (both_modes | (state == SLPM_PASS_END && pass_hit) |
                                       (manual_run & zero_count)); // [R10] [R14]

  // ==========================================================================
  // Sequencer next state.
  // ==========================================================================
  always_comb begin
    next_state = state;
    unique case (state)
      SLPM_IDLE:     if (run_ok) next_state = SLPM_SCAN;
      SLPM_SCAN: begin
        if (!run_ok)        next_state = SLPM_IDLE;   // [R12]
        else if (slave_on)  next_state = SLPM_ISSUE;
        else if (last_slot) next_state = SLPM_PASS_END;
      end
      SLPM_ISSUE:    if (i_req_ready) next_state = SLPM_WAIT;
      SLPM_WAIT: begin
        if (i_rsp.done) begin
          if (!simul_rw && !write_phase) next_state = SLPM_ISSUE; // [R06]
          else if (last_slot)            next_state = SLPM_PASS_END;
          else                           next_state = SLPM_SCAN;
        end
      end
      SLPM_PASS_END: next_state = (pass_hit || !run_ok) ? SLPM_IDLE : SLPM_SCAN; // [R12]
    endcase
  end

  // The request word is built from selection logic and held in a register.
  always_comb begin
    next_req.station  = station;
    next_req.extended = protocol; // [R15]
    if (simul_rw)         next_req.op = SLPM_OP_RW; // [R05]
    else if (next_write)  next_req.op = SLPM_OP_WRITE;
    else                  next_req.op = SLPM_OP_READ;
  end

  assign o_req_valid = (state == SLPM_ISSUE);
  assign o_busy      = (state != SLPM_IDLE);
  assign o_error     = zero_count | conflict_error | timeout_flag;

  // ==========================================================================
  // Sequencer state, slot index and read/write phase.
  // ==========================================================================
  always_ff @(posedge i_clock) begin
    if (i_rst) state <= SLPM_IDLE;
    else       state <= next_state;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      index <= 5'h00;
    end else if (state == SLPM_IDLE || state == SLPM_PASS_END) begin
      index <= 5'h00;
    end else if ((state == SLPM_SCAN && run_ok && !slave_on && !last_slot) ||
                 (state == SLPM_WAIT && next_state == SLPM_SCAN)) begin
      index <= 5'(index + 5'h01);
    end
  end

  // The request word loads from the coming phase, or a read would be sent twice.
  assign next_write = (state == SLPM_WAIT && i_rsp.done) ? (~simul_rw & ~write_phase) :
                      (state == SLPM_SCAN) ? 1'b0 : write_phase; // [R06]

  always_ff @(posedge i_clock) begin
    if (i_rst) write_phase <= 1'b0;
    else       write_phase <= next_write;
  end

  // Request word registered so the engine sees stable data while valid.
  always_ff @(posedge i_clock) begin
    if (i_rst)                    o_req <= '0;
    else if (state != SLPM_ISSUE) o_req <= next_req;
  end

  // ==========================================================================
  // Pass counter.
  // ==========================================================================
  // A new manual run is the software write that raises link enable.
  wire logic run_start = ctl_write & i_writedata[CTL_LINK_ENABLE] & i_writedata[CTL_MANUAL_RUN];

  always_ff @(posedge i_clock) begin
    if (i_rst)                                  done_count <= 16'h0000;
    else if (run_start)                         done_count <= 16'h0000; // [R17]
    else if (state == SLPM_PASS_END && manual_run)
      done_count <= 16'(done_count + 16'h0001); // [R07] [R17]
  end

  // ==========================================================================
  // Error and timeout flags.
  // ==========================================================================
  // Conflict stays until a run starts again cleanly; set wins over clear.
  always_ff @(posedge i_clock) begin
    if (i_rst)                            conflict_error <= 1'b0;
    else if (both_modes & link_enable)    conflict_error <= 1'b1; // [R14]
    else if (state == SLPM_SCAN && run_ok) conflict_error <= 1'b0;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timeout_flag <= 1'b0;
    end else if (state == SLPM_WAIT && i_rsp.done) begin
      timeout_flag <= i_rsp.timeout; // [R16]
    end
  end

endmodule

/* File: slpm_pkg.sv */
package slpm_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned 32-bit word each).
  // ==========================================================================
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_FIRST_ADDR = 8'h08;
  localparam logic [7:0] ADDR_LINK_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_TARGET     = 8'h10;
  localparam logic [7:0] ADDR_DONE       = 8'h14;
  localparam logic [7:0] ADDR_STN_BASE   = 8'h40;
  localparam logic [7:0] ADDR_STN_LAST   = 8'hBC;

  // ==========================================================================
  // Control register bit positions.
  // ==========================================================================
  localparam int CTL_LINK_ENABLE  = 0;
  localparam int CTL_AUTO_RUN     = 1;
  localparam int CTL_MANUAL_RUN   = 2;
  localparam int CTL_USER_FLAGS   = 3;
  localparam int CTL_MANUAL_ADDR  = 4;
  localparam int CTL_SIMUL_RW     = 5;
  localparam int CTL_PROTOCOL_SEL = 6;
  localparam int CTL_WIDTH        = 7;

  // ==========================================================================
  // Status register bit positions.
  // ==========================================================================
  localparam int STS_ZERO_COUNT = 0;
  localparam int STS_CONFLICT   = 1;
  localparam int STS_TIMEOUT    = 2;
  localparam int STS_BUSY       = 3;

  // ==========================================================================
  // Sizes and reset values.
  // ==========================================================================
  localparam int          NUM_SLAVES        = 32;
  localparam logic [7:0]  RST_FIRST_ADDR    = 8'h01;
  localparam logic [15:0] RST_TARGET        = 16'h0001;
  localparam logic [31:0] RST_LINK_FLAGS    = 32'h00000000;
  localparam logic [CTL_WIDTH-1:0] RST_CONTROL = 7'h00;

  // ==========================================================================
  // Exchange kinds sent to the serial transaction engine.
  // ==========================================================================
  typedef enum logic [1:0] {
    SLPM_OP_READ  = 2'h0,
    SLPM_OP_WRITE = 2'h1,
    SLPM_OP_RW    = 2'h2
  } slpm_op_t;

  // One request to the transaction engine.
  typedef struct packed {
    logic [7:0] station;
    slpm_op_t   op;
    logic       extended;
  } slpm_req_t;

  // Answer from the transaction engine.
  typedef struct packed {
    logic done;
    logic timeout;
  } slpm_rsp_t;

endpackage

/* File: slpm_addr_gen.sv */
module slpm_addr_gen
  import slpm_pkg::*;
(
  // Selection.
  input  wire logic             i_manual_addr,
  input  wire logic [7:0]       i_first_addr,
  input  wire logic [4:0]       i_index,
  input  wire logic [7:0]       i_user_addr,
  // Result.
  output      logic [7:0]       o_station
);

  // ==========================================================================
  // Station address choice.
  // ==========================================================================
  // Consecutive addresses wrap at eight bits; software keeps the range sane.
  wire logic [7:0] auto_addr = 8'(i_first_addr + {3'h0, i_index}); // [R02]
  assign o_station = i_manual_addr ? i_user_addr : auto_addr;      // [R01]

endmodule

/* File: slpm_regs.sv */
module slpm_regs
  import slpm_pkg::*;
(
  // Clock and reset.
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // Avalon-MM slave.
  input  wire logic [7:0]           i_address,
  input  wire logic                 i_read,
  input  wire logic                 i_write,
  input  wire logic [31:0]          i_writedata,
  input  wire logic [3:0]           i_byteenable,
  output      logic [31:0]          o_readdata,
  output      logic                 o_waitrequest,
  // Register contents.
  output      logic [CTL_WIDTH-1:0] o_control,
  output      logic                 o_ctl_write,
  output      logic [7:0]           o_first_addr,
  output      logic [31:0]          o_link_flags,
  output      logic [15:0]          o_target,
  input  wire logic [4:0]           i_stn_index,
  output      logic [7:0]           o_stn_addr,
  // Hardware side.
  input  wire logic                 i_clear_enable,
  input  wire logic [3:0]           i_status,
  input  wire logic [15:0]          i_done_count
);

  logic [7:0] stn_table [NUM_SLAVES];
  logic       ack;

  // ==========================================================================
  // Decode.
  // ==========================================================================
  wire logic access  = (i_read | i_write) & ~ack;
  // Writes land only at the edge where waitrequest is sampled low.
  wire logic wr      = i_write & ack;
  wire logic in_stn  = (i_address >= ADDR_STN_BASE) && (i_address <= ADDR_STN_LAST);
  wire logic [4:0] stn_sel = 5'((i_address - ADDR_STN_BASE) >> 2);
  wire logic wr_ctl  = wr && i_address == ADDR_CONTROL && i_byteenable[0];
  wire logic wr_fst  = wr && i_address == ADDR_FIRST_ADDR && i_byteenable[0];
  wire logic wr_flg  = wr && i_address == ADDR_LINK_FLAGS;
  wire logic wr_tgt  = wr && i_address == ADDR_TARGET;
  wire logic wr_stn  = wr && in_stn && i_byteenable[0];
  assign o_waitrequest = (i_read | i_write) & ~ack;
  assign o_ctl_write   = wr_ctl;
  assign o_stn_addr    = stn_table[i_stn_index];

  // Every access answers one cycle after it is presented.
  always_ff @(posedge i_clock) begin
    if (i_rst) ack <= 1'b0;
    else       ack <= access;
  end

  // Control: a hardware clear of link_enable wins only when software is not
  // writing the same cycle, so a restart written at the stop is not lost.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_control <= RST_CONTROL;
    end else if (wr_ctl) begin
      o_control <= i_writedata[CTL_WIDTH-1:0];
    end else if (i_clear_enable) begin
      o_control[CTL_LINK_ENABLE] <= 1'b0;
    end
  end

  // Plain configuration words, byte lanes honoured.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_first_addr <= RST_FIRST_ADDR;
      o_link_flags <= RST_LINK_FLAGS;
      o_target     <= RST_TARGET;
    end else begin
      if (wr_fst) o_first_addr <= i_writedata[7:0];
      for (int b = 0; b < 4; b++) begin
        if (wr_flg && i_byteenable[b]) o_link_flags[b*8 +: 8] <= i_writedata[b*8 +: 8];
      end
      for (int b = 0; b < 2; b++) begin
        if (wr_tgt && i_byteenable[b]) o_target[b*8 +: 8] <= i_writedata[b*8 +: 8];
      end
    end
  end

  // User station table; no reset needed since software loads it before use.
  always_ff @(posedge i_clock) begin
    if (wr_stn) stn_table[stn_sel] <= i_writedata[7:0];
  end

  // Read data registered at the answer edge; unmapped reads return zero.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_readdata <= 32'h00000000;
    end else if (i_read & ~ack) begin
      unique case (1'b1)
        i_address == ADDR_CONTROL:    o_readdata <= 32'(o_control);
        i_address == ADDR_STATUS:     o_readdata <= 32'(i_status);
        i_address == ADDR_FIRST_ADDR: o_readdata <= 32'(o_first_addr);
        i_address == ADDR_LINK_FLAGS: o_readdata <= o_link_flags;
        i_address == ADDR_TARGET:     o_readdata <= 32'(o_target);
        i_address == ADDR_DONE:       o_readdata <= 32'(i_done_count);
        in_stn:                       o_readdata <= 32'(stn_table[stn_sel]);
        default:                      o_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* File: slpm_monitor.sv */
module slpm_monitor
  import slpm_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Register bus.
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic        o_waitrequest,
  // Engine link and status.
  input  wire logic        o_req_valid,
  input  wire logic        i_req_ready,
  input  wire slpm_req_t   o_req,
  input  wire slpm_rsp_t   i_rsp,
  input  wire logic        o_busy,
  input  wire logic        o_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_open;
  logic [7:0] rd_stn;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // Helper state
  // ==========================================================================
  // Remembers an accepted read so the paired write can be matched to it.
  always_ff @(posedge i_clock) begin
    if (i_rst || !o_busy) begin
      rd_open <= 1'b0;
    end else if (o_req_valid && i_req_ready) begin
      rd_open <= (o_req.op == SLPM_OP_READ);
      rd_stn  <= o_req.station;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  a_wait_first: assert property ((i_read || i_write) && !$past(i_read || i_write)
    |-> o_waitrequest) else $error("waitrequest low on first request cycle");
  a_wait_release: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("waitrequest held past one cycle");
  a_req_hold: assert property (o_req_valid && !i_req_ready
    |=> o_req_valid && $stable(o_req)) else $error("request changed before ready");
  a_accept_wait: assert property (o_req_valid && i_req_ready
    |=> !o_req_valid) else $error("new request before answer");
  a_idle_quiet: assert property (!o_busy |-> !o_req_valid)
    else $error("request while idle");
  a_op_legal: assert property (o_req_valid |-> o_req.op inside
    {SLPM_OP_READ, SLPM_OP_WRITE, SLPM_OP_RW}) else $error("illegal op");
  a_write_pair: assert property (o_req_valid && i_req_ready && rd_open
    |-> o_req.op == SLPM_OP_WRITE && o_req.station == rd_stn)
    else $error("read not followed by its write");
  a_timeout_err: assert property (i_rsp.done && i_rsp.timeout && o_busy
    && !o_req_valid |-> ##[1:2] o_error) else $error("timeout not flagged");
endmodule

/* File: slpm_engine_model.sv */
module slpm_engine_model
  import slpm_pkg::*;
(
  // Clock and reset.
  input  wire logic      i_clock,
  input  wire logic      i_rst,
  // Request side.
  input  wire logic      i_req_valid,
  output      logic      o_req_ready,
  // Answer side.
  output      slpm_rsp_t o_rsp,
  // Behaviour controls.
  input  wire logic      i_slow,
  input  wire logic      i_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend;
  logic [3:0] cnt;
  logic       junk;
  logic       rsp_done;

  // Ready is held back while an answer or a slow recovery is counting down.
  assign o_req_ready = i_req_valid && !pend && (cnt == 4'h0);
  assign rsp_done    = pend && (cnt == 4'h0);
  // Outside an answer the timeout line toggles, so a stale value is never read.
  assign o_rsp = '{done: rsp_done, timeout: rsp_done ? i_timeout : junk};

  // One exchange at a time; slow mode stretches both the answer and the next ready.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pend <= 1'b0;
      cnt  <= 4'h0;
      junk <= 1'b0;
    end else begin
      junk <= !junk;
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (o_req_ready) begin
        pend <= 1'b1;
        cnt  <= i_slow ? 4'h5 : 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        cnt  <= i_slow ? 4'h3 : 4'h0;
      end
    end
  end
endmodule

/* File: slpm_top_tb.sv */
module slpm_top_tb;
  import slpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] C_EN  = 7'h01 << CTL_LINK_ENABLE;
  localparam logic [6:0] C_AU  = 7'h01 << CTL_AUTO_RUN;
  localparam logic [6:0] C_MAN = 7'h01 << CTL_MANUAL_RUN;
  localparam logic [6:0] C_UF  = 7'h01 << CTL_USER_FLAGS;
  localparam logic [6:0] C_MA  = 7'h01 << CTL_MANUAL_ADDR;
  localparam logic [6:0] C_SIM = 7'h01 << CTL_SIMUL_RW;
  localparam logic [6:0] C_PS  = 7'h01 << CTL_PROTOCOL_SEL;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_address = 8'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic        o_waitrequest, o_req_valid, i_req_ready, o_busy, o_error;
  slpm_req_t   o_req;
  slpm_rsp_t   i_rsp;
  logic        slow = 1'b0;
  logic        tmo = 1'b0;
  slpm_req_t   log_q[$];
  int          fails = 0;
  int          checks = 0;
  int          n, sz;

  always #20 i_clock = ~i_clock;

  slpm_top u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_req_valid(o_req_valid),
    .i_req_ready(i_req_ready), .o_req(o_req), .i_rsp(i_rsp), .o_busy(o_busy),
    .o_error(o_error));
  slpm_engine_model u_eng (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(o_req_valid),
    .o_req_ready(i_req_ready), .o_rsp(i_rsp), .i_slow(slow), .i_timeout(tmo));

  // Every request the engine accepts is logged for later comparison.
  always @(posedge i_clock) begin
    if (o_req_valid === 1'b1 && i_req_ready === 1'b1) log_q.push_back(o_req);
  end

  // ==========================================================================
  // Bus and compare tasks
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waitrequest and read data are taken at the rising edge, as the slave sees them.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge i_clock);
    i_address   <= a;
    i_writedata <= d;
    i_write     <= wr;
    i_read      <= !wr;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 50);
    q = o_readdata;
    if (k >= 50) fails++;
    i_read  <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, exp);
  endtask
  task automatic check_req(input int i, input logic [7:0] s, input slpm_op_t op,
                           input logic x);
    check(32'(log_q[i]), 32'({s, op, x}));
  endtask
  // Starts a run and waits, bounded, until the sequencer is idle again.
  task automatic run(input logic [6:0] ctl);
    int k;
    k = 0;
    log_q.delete();
    wr(ADDR_CONTROL, 32'(ctl));
    repeat (3) @(negedge i_clock);
    while (o_busy !== 1'b0 && k < 5000) begin
      @(negedge i_clock);
      k++;
    end
    if (k >= 5000) fails++;
    @(posedge i_clock);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The longest run is a few hundred cycles, so this bound is generous.
  initial begin
    repeat (40000) @(posedge i_clock);
    fails++;
    finish_test();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_chk(ADDR_CONTROL, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_FIRST_ADDR, 32'h1);
    rd_chk(ADDR_LINK_FLAGS, 32'h0);
    rd_chk(ADDR_TARGET, 32'h1);
    rd_chk(ADDR_DONE, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0);
    // Automatic addressing, all slots, separate read and write, two passes.
    wr(ADDR_FIRST_ADDR, 32'h10);
    wr(ADDR_TARGET, 32'h2);
    run(C_EN | C_MAN);
    check(32'(log_q.size()), 32'h80);
    for (int i = 0; i < 128; i++) begin
      check_req(i, 8'h10 + 8'((i / 2) % 32), (i % 2) ? SLPM_OP_WRITE : SLPM_OP_READ, 1'b0);
    end
    rd_chk(ADDR_DONE, 32'h2);
    rd_chk(ADDR_CONTROL, 32'h0, 32'h1);
    // User addresses and flags, combined exchange, extended framing, slow engine.
    slow <= 1'b1;
    wr(ADDR_STN_BASE + 8'h0C, 32'h55);
    wr(ADDR_STN_BASE + 8'h1C, 32'h66);
    wr(ADDR_LINK_FLAGS, 32'h88);
    wr(ADDR_TARGET, 32'h1);
    run(C_EN | C_MAN | C_UF | C_MA | C_SIM | C_PS);
    check(32'(log_q.size()), 32'h2);
    check_req(0, 8'h55, SLPM_OP_RW, 1'b1);
    check_req(1, 8'h66, SLPM_OP_RW, 1'b1);
    rd_chk(ADDR_DONE, 32'h1);
    // Timeout sets the flag, a clean exchange clears it.
    slow <= 1'b0;
    tmo  <= 1'b1;
    wr(ADDR_LINK_FLAGS, 32'h1);
    run(C_EN | C_MAN | C_UF | C_SIM);
    rd_chk(ADDR_STATUS, 32'h4, 32'h4);
    check(32'(o_error), 32'h1);
    tmo <= 1'b0;
    run(C_EN | C_MAN | C_UF | C_SIM);
    rd_chk(ADDR_STATUS, 32'h0, 32'h4);
    // A zero target is flagged and refuses to run.
    wr(ADDR_TARGET, 32'h0);
    rd_chk(ADDR_STATUS, 32'h1, 32'h1);
    run(C_EN | C_MAN);
    check(32'(log_q.size()), 32'h0);
    rd_chk(ADDR_CONTROL, 32'h0, 32'h1);
    wr(ADDR_TARGET, 32'h1);
    // Both modes at once is a conflict.
    run(C_EN | C_AU | C_MAN);
    rd_chk(ADDR_STATUS, 32'h2, 32'h2);
    rd_chk(ADDR_CONTROL, 32'h0, 32'h1);
    check(32'(o_error), 32'h1);
    // Auto mode keeps polling until enable drops, then goes quiet.
    wr(ADDR_LINK_FLAGS, 32'h3);
    log_q.delete();
    wr(ADDR_CONTROL, 32'(C_EN | C_AU | C_UF | C_SIM));
    n = 0;
    while (log_q.size() < 6 && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
    check(32'(log_q.size() >= 6), 32'h1);
    run(C_AU | C_UF | C_SIM);
    sz = log_q.size();
    repeat (20) @(posedge i_clock);
    check(32'(log_q.size()), 32'(sz));
    rd_chk(ADDR_STATUS, 32'h0, 32'h2);
    // The last two manual starts cleared the count and auto passes never add to it.
    rd_chk(ADDR_DONE, 32'h0);
    finish_test();
  end
endmodule

bind slpm_top slpm_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_read(i_read),
  .i_write(i_write), .o_waitrequest(o_waitrequest), .o_req_valid(o_req_valid),
  .i_req_ready(i_req_ready), .o_req(o_req), .i_rsp(i_rsp), .o_busy(o_busy),
  .o_error(o_error));
